// [pkg/sim_pkg.sv]
`default_nettype none
package sim_pkg;
   // register map
   localparam int SIM_ADDR_W = 4;
   localparam logic [SIM_ADDR_W-1:0] SIM_CSR_OFS = 4'h0;
   localparam logic [7:0] SIM_CSR_RST = 8'h00;
   // field positions
   localparam int SIM_WATCHDOG_RESET_FLAG_BIT = 0;
   localparam int SIM_UNDERVOLTAGE_RESET_FLAG_BIT = 4;
   localparam int SIM_FLAG_BIT = 5;
   localparam int SIM_IE_BIT = 6;
   // reset sequence timing, in cpu clock cycles
   localparam int SIM_CNT_W = 13;
   localparam logic [SIM_CNT_W-1:0] SIM_DLY_SHORT = 13'h0100;
   localparam logic [SIM_CNT_W-1:0] SIM_DLY_LONG = 13'h1000;
   localparam logic [SIM_CNT_W-1:0] SIM_FETCH_CYC = 13'h0002;
   localparam logic [SIM_CNT_W-1:0] SIM_ACT_MIN_DEF = 13'h0004;
   // register bus request
   typedef struct packed {
      logic wr;
      logic rd;
      logic [SIM_ADDR_W-1:0] addr;
      logic [7:0] wdata;
   } sim_bus_req_t;
   // reset sequence phases
   typedef enum logic [1:0] {
      SIM_RUN,
      SIM_ACTIVE,
      SIM_DELAY,
      SIM_FETCH
   } sim_seq_t;
endpackage
`default_nettype wire

// [rtl/sim_sync2.sv]
`timescale 1ns/100ps
`default_nettype none
module sim_sync2 #(
   parameter int W = 1
) (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic [W-1:0] async_i,
   output logic [W-1:0] sync_o
);
   logic [W-1:0] meta_q;
   logic [W-1:0] sync_q;

   // two flops, first read only by second
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= async_i;
         sync_q <= meta_q;
      end
   end

   assign sync_o = sync_q;
endmodule // sim_sync2
`default_nettype wire

// [rtl/sim_supply_monitor.sv]
// How it works
// - static reset while detector reports low supply
// - drive reset pin low during that reset
// - detector enable is a strap, not register
// - warning logic runs only with detector enabled
// - warning flag follows comparator, read only
// - each flag change raises irq when enabled
// - pending irq cleared on service entry
// - no irq for crossing inside reset delay
// - enable while below: irq now, another later
// - enable when above: one irq only
// - irq forwarded only if enabled and unmasked
// - wake from wait, never from halt
// - register frozen during halt
// - undervoltage flag set by hw, zero write clears
// - pin or watchdog reset keeps undervoltage flag
// - watchdog flag set by hw, cleared by low-voltage
// - two flags together name the reset source
// - flags meaningless with detector disabled
// - release, then 256/4096 delay, then 2-cycle fetch
//
// The register addresses and the plain strobed port were decided locally.
`timescale 1ns/100ps
`default_nettype none
module sim_supply_monitor
   import sim_pkg::*;
#(
   parameter logic [SIM_CNT_W-1:0] ACT_MIN = SIM_ACT_MIN_DEF
) (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire sim_bus_req_t bus_req,
   output logic [7:0] rd_data,
   input wire logic strap_lvd_en,
   input wire logic strap_long_dly,
   input wire logic lvd_below_a,
   input wire logic avd_below_a,
   output logic lvd_thr_high,
   input wire logic rst_pin_i,
   output logic rst_pin_o,
   output logic rst_pin_oe,
   input wire logic wdg_rst_req,
   output logic sys_rst_n,
   output logic vector_fetch,
   input wire logic halt_i,
   input wire logic wait_i,
   input wire logic cc_mask_i,
   input wire logic irq_ack,
   output logic irq_req,
   output logic wake
);
   ////////////////////////////////////////////////////////////////////////
   // synchronisers
   logic lvd_below;
   logic avd_below;
   logic pin_level;

   sim_sync2 #(.W(3)) u_sync (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .async_i({lvd_below_a, avd_below_a, rst_pin_i}),
      .sync_o({lvd_below, avd_below, pin_level})
   );

   ////////////////////////////////////////////////////////////////////////
   // straps, caught once after reset release
   logic taken_q;
   logic lvd_en_q;
   logic long_dly_q;

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         taken_q <= 1'b0;
         lvd_en_q <= 1'b0;
         long_dly_q <= 1'b0;
      end else if (!taken_q) begin
         taken_q <= 1'b1;
         lvd_en_q <= strap_lvd_en;
         long_dly_q <= strap_long_dly;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // reset sequencer
   sim_seq_t state_q;
   logic [SIM_CNT_W-1:0] cnt_q;
   logic [SIM_CNT_W-1:0] dly_cyc;
   logic lvd_active;
   logic ext_low;
   logic run;

   assign dly_cyc = long_dly_q ? SIM_DLY_LONG : SIM_DLY_SHORT;
   assign lvd_active = taken_q & lvd_en_q & lvd_below;
   assign run = (state_q == SIM_RUN);
   // pin is only an input in the run phase, not while the sequence drives it or fetches
   assign ext_low = run & ~pin_level;

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         state_q <= SIM_ACTIVE;
         cnt_q <= '0;
      end else begin
         case (state_q)
            SIM_RUN: begin
               if (lvd_active | wdg_rst_req | ext_low) begin
                  state_q <= SIM_ACTIVE;
                  cnt_q <= '0;
               end
            end
            SIM_ACTIVE: begin
               if (lvd_active) begin
                  cnt_q <= '0;
               end else if (cnt_q >= ACT_MIN - 13'h0001) begin
                  state_q <= SIM_DELAY;
                  cnt_q <= '0;
               end else begin
                  cnt_q <= cnt_q + 13'h0001;
               end
            end
            SIM_DELAY: begin
               if (lvd_active) begin
                  state_q <= SIM_ACTIVE;
                  cnt_q <= '0;
               end else if (cnt_q == dly_cyc - 13'h0001) begin
                  state_q <= SIM_FETCH;
                  cnt_q <= '0;
               end else begin
                  cnt_q <= cnt_q + 13'h0001;
               end
            end
            SIM_FETCH: begin
               if (lvd_active) begin
                  state_q <= SIM_ACTIVE;
                  cnt_q <= '0;
               end else if (cnt_q == SIM_FETCH_CYC - 13'h0001) begin
                  state_q <= SIM_RUN;
                  cnt_q <= '0;
               end else begin
                  cnt_q <= cnt_q + 13'h0001;
               end
            end
            default: begin
               state_q <= SIM_ACTIVE;
               cnt_q <= '0;
            end
         endcase
      end
   end

   // pin held low in active and delay phases
   assign rst_pin_o = 1'b0;
   assign rst_pin_oe = (state_q == SIM_ACTIVE) | (state_q == SIM_DELAY);
   assign sys_rst_n = run;
   assign vector_fetch = (state_q == SIM_FETCH);
   // rising threshold while held in reset, falling one when running
   assign lvd_thr_high = ~run;

   ////////////////////////////////////////////////////////////////////////
   // register access
   logic hit_wr;
   logic hit_rd;
   logic frozen;
   logic ie_q;
   logic ie_prev_q;
   logic flag_q;
   logic flag_prev_q;
   logic undervoltage_reset_flag_q;
   logic watchdog_reset_flag_q;
   logic pend_q;
   logic pend_set;
   logic toggle;
   logic [7:0] csr;

   assign frozen = halt_i & run;
   assign hit_wr = bus_req.wr & (bus_req.addr == SIM_CSR_OFS) & ~frozen;
   assign hit_rd = bus_req.rd & (bus_req.addr == SIM_CSR_OFS);

   always_comb begin
      csr = SIM_CSR_RST;
      csr[SIM_IE_BIT] = ie_q;
      csr[SIM_FLAG_BIT] = flag_q;
      csr[SIM_UNDERVOLTAGE_RESET_FLAG_BIT] = undervoltage_reset_flag_q;
      csr[SIM_WATCHDOG_RESET_FLAG_BIT] = watchdog_reset_flag_q;
   end

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         rd_data <= SIM_CSR_RST;
      end else begin
         rd_data <= hit_rd ? csr : 8'h00;
      end
   end

   // interrupt enable, cleared by any system reset
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         ie_q <= 1'b0;
         ie_prev_q <= 1'b0;
      end else begin
         ie_prev_q <= ie_q;
         if (!run) begin
            ie_q <= 1'b0;
         end else if (hit_wr) begin
            ie_q <= bus_req.wdata[SIM_IE_BIT];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // reset source flags
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         undervoltage_reset_flag_q <= 1'b0;
      end else if (lvd_active) begin
         undervoltage_reset_flag_q <= 1'b1;
      end else if (hit_wr & ~bus_req.wdata[SIM_UNDERVOLTAGE_RESET_FLAG_BIT]) begin
         undervoltage_reset_flag_q <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         watchdog_reset_flag_q <= 1'b0;
      end else if (lvd_active) begin
         watchdog_reset_flag_q <= 1'b0;
      end else if (run & wdg_rst_req) begin
         watchdog_reset_flag_q <= 1'b1;
      end else if (hit_wr & ~bus_req.wdata[SIM_WATCHDOG_RESET_FLAG_BIT]) begin
         watchdog_reset_flag_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // supply warning flag and interrupt
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         flag_q <= 1'b0;
         flag_prev_q <= 1'b0;
      end else begin
         if (!frozen) begin
            flag_prev_q <= flag_q;
         end
         if (!lvd_en_q) begin
            flag_q <= 1'b0;
         end else if (!frozen) begin
            flag_q <= avd_below;
         end
      end
   end

   assign toggle = flag_q ^ flag_prev_q;
   // crossings inside the reset sequence are dropped
   assign pend_set = run & ~frozen & lvd_en_q &
      ((toggle & ie_q) | (ie_q & ~ie_prev_q & flag_q));

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         pend_q <= 1'b0;
      end else if (pend_set) begin
         pend_q <= 1'b1;
      end else if ((!lvd_en_q | !run | irq_ack) & !frozen) begin
         pend_q <= 1'b0;
      end
   end

   assign irq_req = pend_q & ie_q & ~cc_mask_i;
   assign wake = irq_req & wait_i & ~halt_i;

   ////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);

   property p_lvd_hold;
      lvd_active |=> (state_q == SIM_ACTIVE) && !sys_rst_n;
   endproperty
   a_lvd_hold: assert property (p_lvd_hold)
      else $error("reset not held under low supply");

   property p_pin_low;
      lvd_active |=> rst_pin_oe && !rst_pin_o;
   endproperty
   a_pin_low: assert property (p_pin_low)
      else $error("reset pin not driven low");

   property p_strap;
      taken_q && $past(taken_q) |-> $stable(lvd_en_q);
   endproperty
   a_strap: assert property (p_strap)
      else $error("detector enable changed after power-up");

   property p_avd_off;
      taken_q && !lvd_en_q |=> !flag_q && !pend_q && !irq_req;
   endproperty
   a_avd_off: assert property (p_avd_off)
      else $error("warning active with detector off");

   property p_flag;
      lvd_en_q && !frozen |=> flag_q == $past(avd_below);
   endproperty
   a_flag: assert property (p_flag)
      else $error("warning flag not following comparator");

   property p_toggle;
      run && !frozen && lvd_en_q && ie_q &&
         (flag_q != flag_prev_q) |=> pend_q;
   endproperty
   a_toggle: assert property (p_toggle)
      else $error("flag change raised no interrupt");

   property p_ack;
      irq_ack && !pend_set && !frozen |=> !pend_q;
   endproperty
   a_ack: assert property (p_ack)
      else $error("pending not cleared on service entry");

   property p_seq_quiet;
      !run |=> !pend_q;
   endproperty
   a_seq_quiet: assert property (p_seq_quiet)
      else $error("interrupt pending during reset sequence");

   property p_en_below;
      run && lvd_en_q && ie_q && !ie_prev_q && flag_q |=> pend_q;
   endproperty
   a_en_below: assert property (p_en_below)
      else $error("no interrupt on enabling below threshold");

   property p_mask;
      irq_req |-> ie_q && !cc_mask_i && pend_q;
   endproperty
   a_mask: assert property (p_mask)
      else $error("interrupt forwarded while masked");

   property p_halt;
      halt_i |-> !wake;
   endproperty
   a_halt: assert property (p_halt)
      else $error("warning woke from halt");

   property p_freeze;
      frozen |=> $stable(ie_q) && $stable(flag_q) && $stable(pend_q);
   endproperty
   a_freeze: assert property (p_freeze)
      else $error("register changed during halt");

   property p_undervoltage_reset_flag;
      lvd_active |=> undervoltage_reset_flag_q ##1 (undervoltage_reset_flag_q || $past(hit_wr));
   endproperty
   a_undervoltage_reset_flag: assert property (p_undervoltage_reset_flag)
      else $error("undervoltage flag not set");

   property p_keep;
      (wdg_rst_req || ext_low) && !lvd_active && !hit_wr |=> $stable(undervoltage_reset_flag_q);
   endproperty
   a_keep: assert property (p_keep)
      else $error("undervoltage flag lost on other reset");

   property p_wdg_clr;
      lvd_active |=> !watchdog_reset_flag_q;
   endproperty
   a_wdg_clr: assert property (p_wdg_clr)
      else $error("watchdog flag kept across low-voltage reset");

   property p_fetch;
      $rose(state_q == SIM_FETCH) |->
         $past(cnt_q) == dly_cyc - 13'h0001 ##1 (vector_fetch || !run)
         ##1 (run || lvd_active || $past(lvd_active));
   endproperty
   a_fetch: assert property (p_fetch)
      else $error("delay or fetch phase length wrong");

   c_lvd_reset: cover property (lvd_active ##1 undervoltage_reset_flag_q);
   c_wdg_reset: cover property (run && wdg_rst_req ##1 watchdog_reset_flag_q);
   c_en_below: cover property (run && ie_q && !ie_prev_q && flag_q
      ##1 pend_q);
   c_toggle_irq: cover property (irq_req ##1 irq_ack ##1 !pend_q);
endmodule // sim_supply_monitor
`default_nettype wire

// [tb/sim_testbench.sv]
`timescale 1ns/100ps
`default_nettype none
module testbench
   import sim_pkg::*;
;
   localparam int ACT = 4;
   logic sys_clk = 1'b0;
   logic resetn = 1'b0;
   sim_bus_req_t bus_req = '0;
   logic [7:0] rd_data;
   logic strap_lvd_en = 1'b1;
   logic strap_long_dly = 1'b0;
   logic lvd_below_a = 1'b0;
   logic avd_below_a = 1'b0;
   logic ext_pin = 1'b1;
   logic halt_i = 1'b0;
   logic wait_i = 1'b0;
   logic cc_mask_i = 1'b0;
   logic irq_ack = 1'b0;
   logic wdg_rst_req = 1'b0;
   logic lvd_thr_high, rst_pin_o, rst_pin_oe, sys_rst_n, vector_fetch;
   logic irq_req, wake, rst_pin_i;
   int failures = 0;
   int total_checks = 0;
   ////////////////////////////////////////////////////////////////////////
   // pin level: own open-drain pull or external driver, pull-up otherwise
   assign rst_pin_i = rst_pin_oe ? rst_pin_o : ext_pin;
   always #25 sys_clk = ~sys_clk;
   sim_supply_monitor #(.ACT_MIN(13'(ACT))) dut (
      .sys_clk(sys_clk), .resetn(resetn), .bus_req(bus_req),
      .rd_data(rd_data), .strap_lvd_en(strap_lvd_en),
      .strap_long_dly(strap_long_dly), .lvd_below_a(lvd_below_a),
      .avd_below_a(avd_below_a), .lvd_thr_high(lvd_thr_high),
      .rst_pin_i(rst_pin_i), .rst_pin_o(rst_pin_o),
      .rst_pin_oe(rst_pin_oe), .wdg_rst_req(wdg_rst_req),
      .sys_rst_n(sys_rst_n), .vector_fetch(vector_fetch),
      .halt_i(halt_i), .wait_i(wait_i), .cc_mask_i(cc_mask_i),
      .irq_ack(irq_ack), .irq_req(irq_req), .wake(wake)
   );
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input string w, input logic [7:0] e,
                      input logic [7:0] g);
      total_checks++;
      if (g !== e) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", w, e, g);
      end
   endtask
   task automatic chk1(input string w, input logic e, input logic g);
      total_checks++;
      if (g !== e) begin
         failures++;
         $display("MISMATCH %s expected %b seen %b", w, e, g);
      end
   endtask
   task automatic chk_n(input string w, input int e, input int g);
      total_checks++;
      if (g != e) begin
         failures++;
         $display("MISMATCH %s expected %0d seen %0d", w, e, g);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      bus_req.wr <= 1'b1;
      bus_req.addr <= a;
      bus_req.wdata <= d;
      @(posedge sys_clk);
      bus_req.wr <= 1'b0;
   endtask
   task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
      @(posedge sys_clk);
      bus_req.rd <= 1'b1;
      bus_req.addr <= a;
      @(posedge sys_clk);
      bus_req.rd <= 1'b0;
      #1;
      chk("read data", e, rd_data);
   endtask
   // pulse service entry, pending must drop
   task automatic ack();
      @(posedge sys_clk);
      irq_ack <= 1'b1;
      @(posedge sys_clk);
      irq_ack <= 1'b0;
      #1;
      chk1("irq after ack", 1'b0, irq_req);
   endtask
   // follow a reset sequence to run, counting pin-low and fetch cycles
   task automatic seq_run(input int oe_exp);
      int oe_n;
      int fe_n;
      oe_n = 0;
      fe_n = 0;
      for (int i = 0; i < 6000 && sys_rst_n !== 1'b1; i++) begin
         @(posedge sys_clk);
         #1;
         if (rst_pin_oe === 1'b1) oe_n++;
         if (vector_fetch === 1'b1) fe_n++;
      end
      chk1("run reached", 1'b1, sys_rst_n);
      chk_n("fetch cycles", 2, fe_n);
      if (oe_exp > 0) chk_n("delay cycles", oe_exp, oe_n);
   endtask
   task automatic power_on(input logic en);
      resetn <= 1'b0;
      strap_lvd_en <= en;
      tick(16);
      chk1("core reset", 1'b0, sys_rst_n);
      resetn <= 1'b1;
      seq_run(0);
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic t_wdg(input int dly);
      @(posedge sys_clk);
      wdg_rst_req <= 1'b1;
      @(posedge sys_clk);
      wdg_rst_req <= 1'b0;
      #1;
      chk1("pin drive", 1'b1, rst_pin_oe);
      seq_run(ACT + dly - 1);
      rd_chk(SIM_CSR_OFS, 8'h01);
   endtask
   task automatic t_lvd();
      lvd_below_a <= 1'b1;
      avd_below_a <= 1'b1;
      tick(20);
      chk1("core reset", 1'b0, sys_rst_n);
      chk1("pin drive", 1'b1, rst_pin_oe);
      chk1("pin level", 1'b0, rst_pin_o);
      chk1("rising thr", 1'b1, lvd_thr_high);
      avd_below_a <= 1'b0;
      lvd_below_a <= 1'b0;
      seq_run(0);
      chk1("falling thr", 1'b0, lvd_thr_high);
      chk1("irq in delay", 1'b0, irq_req);
      rd_chk(SIM_CSR_OFS, 8'h10);
      ext_pin <= 1'b0;
      tick(6);
      ext_pin <= 1'b1;
      seq_run(0);
      rd_chk(SIM_CSR_OFS, 8'h10);
      wr(SIM_CSR_OFS, 8'h8e);
      rd_chk(SIM_CSR_OFS, 8'h00);
      rd_chk(4'h3, 8'h00);
   endtask
   task automatic t_irq();
      wr(SIM_CSR_OFS, 8'h60);
      tick(2);
      chk1("irq above", 1'b0, irq_req);
      rd_chk(SIM_CSR_OFS, 8'h40);
      avd_below_a <= 1'b1;
      wait_i <= 1'b1;
      tick(6);
      chk1("irq fall", 1'b1, irq_req);
      chk1("wake", 1'b1, wake);
      rd_chk(SIM_CSR_OFS, 8'h60);
      cc_mask_i <= 1'b1;
      tick(2);
      chk1("irq masked", 1'b0, irq_req);
      cc_mask_i <= 1'b0;
      tick(2);
      chk1("irq unmasked", 1'b1, irq_req);
      ack();
      wait_i <= 1'b0;
      avd_below_a <= 1'b0;
      tick(6);
      chk1("irq rise", 1'b1, irq_req);
      ack();
      wr(SIM_CSR_OFS, 8'h00);
      avd_below_a <= 1'b1;
      tick(6);
      chk1("irq disabled", 1'b0, irq_req);
      wr(SIM_CSR_OFS, 8'h40);
      tick(2);
      chk1("irq on enable", 1'b1, irq_req);
      halt_i <= 1'b1;
      wait_i <= 1'b1;
      tick(2);
      chk1("wake halted", 1'b0, wake);
      chk1("irq held in halt", 1'b1, irq_req);
      halt_i <= 1'b0;
      tick(1);
      chk1("wake in wait", 1'b1, wake);
      ack();
      halt_i <= 1'b1;
      wait_i <= 1'b1;
      wr(SIM_CSR_OFS, 8'h00);
      avd_below_a <= 1'b0;
      tick(6);
      chk1("wake in halt", 1'b0, wake);
      rd_chk(SIM_CSR_OFS, 8'h60);
      halt_i <= 1'b0;
      wait_i <= 1'b0;
      tick(6);
      chk1("irq after halt", 1'b1, irq_req);
      ack();
   endtask
   task automatic t_strap_off();
      power_on(1'b0);
      lvd_below_a <= 1'b1;
      wr(SIM_CSR_OFS, 8'h40);
      avd_below_a <= 1'b1;
      tick(8);
      chk1("no lvd reset", 1'b1, sys_rst_n);
      chk1("no warning irq", 1'b0, irq_req);
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic summarize();
      $display("checks %0d mismatches %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // about 13500 cycles expected, generous margin
   initial begin
      repeat (30000) @(posedge sys_clk);
      failures++;
      summarize();
   end
   initial begin
      power_on(1'b1);
      rd_chk(SIM_CSR_OFS, SIM_CSR_RST);
      t_wdg(256);
      t_lvd();
      t_irq();
      strap_long_dly <= 1'b1;
      power_on(1'b1);
      t_wdg(4096);
      t_strap_off();
      summarize();
   end
endmodule // testbench
`default_nettype wire
